// ---- hw/sio_edge.sv ----
/*
 Two-flop synchroniser with edge detection for the serial clock pin.
 Assumes the pin is asynchronous to clk.
*/
`timescale 1ns/1ns
module sio_edge (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic ce,
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic [2:0] sync_q;
    logic [2:0] sync_d;

    always_comb begin
        sync_d = ce ? {sync_q[1:0], pin} : sync_q;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync_q <= 3'h7;
        end else begin
            sync_q <= sync_d;
        end
    end

    assign level = sync_q[1];
    assign rise  = sync_q[1] & ~sync_q[2];
    assign fall  = ~sync_q[1] & sync_q[2];
endmodule // sio_edge

// ---- hw/sio_pkg.sv ----
/*
 Constants for the clocked synchronous 8-bit serial shifter: register
 offsets, field positions, reset values, modes and timing counts.
 Assumes a 10 MHz system clock.
*/
package sio_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [3:0] OFF_CTRL   = 4'h0;
    localparam logic [3:0] OFF_DATA   = 4'h1;
    localparam logic [3:0] OFF_STATUS = 4'h2;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int CTRL_SCK_LSB = 0;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_INH_BIT = 6;
    localparam int CTRL_START_BIT = 7;
    localparam logic [7:0] CTRL_RESET = 8'h47;

    // ------------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------------
    localparam int STAT_SHIFT_BIT = 2;
    localparam int STAT_ACTIVE_BIT = 3;
    localparam int STAT_BUF_FULL_BIT = 4;
    localparam int STAT_BUF_EMPTY_BIT = 5;

    // ------------------------------------------------------------------
    // Clock source and transfer modes
    // ------------------------------------------------------------------
    localparam logic [2:0] SCK_EXTERNAL = 3'h7;

    typedef enum logic [1:0] {
        MODE_TX   = 2'b00,
        MODE_RSVD = 2'b01,
        MODE_TXRX = 2'b10,
        MODE_RX   = 2'b11
    } mode_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_WAIT  = 2'b10,
        ST_DONE  = 2'b11
    } state_t;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 10000000;
    localparam int BITS_PER_BYTE = 8;
    localparam logic [2:0] LAST_BIT = 3'h7;
    // Half period of the fastest internal serial clock, in system cycles
    localparam int HALF_BASE = 1;
    localparam int DIV_W = 8;
endpackage

// ---- hw/sio_shifter.sv ----
/*
 Clocked synchronous 8-bit serial shifter with control, data buffer and
 status registers on a plain strobe port. Assumes one system clock, and
 an external peripheral that keeps the pin timing of the serial clock.
*/
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
// How it works
// - Clock source 111 takes the shift clock from the pin as input.
// - Outgoing bits change on the leading edge, incoming sampled on trailing.
// - Leading edge is the pin falling, trailing edge the pin rising.
// - Mode field picks transmit, receive or transmit/receive.
// - Start moves the buffer to the shifter, sent LSB first.
// - Buffer to shifter load marks buffer empty; it raises the interrupt in transmit-only mode, not in transmit/receive.
// - Internal clock transmit: stall clock after 8 bits until a new write.
// - Data out holds the last bit until the next falling clock edge.
// - Start cleared: finish pending data, then clear the active flag.
// - Inhibit stops transmission at once and clears the active flag.
// - Receive LSB first; after 8 bits copy to buffer, raise full interrupt.
// - Internal clock receive: stall the clock until the buffer is read.
// - External clock receive: unread buffer makes later data be dropped.
// - Start cleared in receive: only whole bytes land, then flag clears.
// - Inhibit in receive stops at once, clears flag, buffer invalid.
// - Changing the mode discards the buffer.
// - Internal clock full duplex: hold clock until read and write both done.
// - Internal clock offers seven rates, driven out on the clock pin.
module sio_shifter
    import sio_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       ce,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       sck_in,
    output logic            sck_out,
    output logic            sck_oe,
    input  wire logic       sdi,
    output logic            sdo,
    output logic            serial_irq
);
    import sio_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic ext_rise, ext_fall;
    logic [1:0] sdi_q;
    logic [1:0] sdi_d;

    sio_edge u_sck (
        .clk   (clk),
        .rstn  (rstn),
        .ce    (ce),
        .pin   (sck_in),
        .level (),
        .rise  (ext_rise),
        .fall  (ext_fall)
    );

    always_comb begin
        sdi_d = ce ? {sdi_q[0], sdi} : sdi_q;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sdi_q <= 2'h0;
        end else begin
            sdi_q <= sdi_d;
        end
    end

    // ------------------------------------------------------------------
    // Registers and shifter state
    // ------------------------------------------------------------------
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] buf_q, buf_d;
    logic [7:0] shreg_q, shreg_d;
    logic [2:0] cnt_q, cnt_d;
    logic       full_q, full_d;
    logic       empty_q, empty_d;
    logic       active_q, active_d;
    logic       drop_q, drop_d;
    logic       sdo_q, sdo_d;
    logic       isck_q, isck_d;
    logic       irq_q, irq_d;
    logic [DIV_W-1:0] div_q, div_d;
    logic [7:0] rdata_q, rdata_d;
    state_t     st_q, st_d;

    logic [2:0] sck_sel;
    mode_t      mode;
    logic       start, inhibit, ext_clk;
    logic       do_tx, do_rx;
    logic       lead, trail;
    logic       wr_ctrl, wr_data, rd_data, rd_any;
    logic [DIV_W-1:0] half;
    logic [7:0] status;
    logic [7:0] in_byte;

    assign sck_sel = ctrl_q[CTRL_SCK_LSB +: 3];
    assign mode    = mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
    assign start   = ctrl_q[CTRL_START_BIT];
    assign inhibit = ctrl_q[CTRL_INH_BIT];
    assign ext_clk = (sck_sel == SCK_EXTERNAL);
    assign do_tx   = (mode == MODE_TX) || (mode == MODE_TXRX);
    assign do_rx   = (mode == MODE_RX) || (mode == MODE_TXRX);
    assign wr_ctrl = wr && (addr == OFF_CTRL);
    assign wr_data = wr && (addr == OFF_DATA);
    assign rd_data = rd && (addr == OFF_DATA);
    assign rd_any  = rd;
    // Seven internal rates: half period doubles with each select step
    assign half    = DIV_W'(HALF_BASE) << sck_sel;
    assign in_byte = {sdi_q[1], shreg_q[7:1]};

    // Leading edge is a falling clock, trailing edge a rising clock
    assign lead  = ext_clk ? ext_fall : (isck_q && div_q == '0 && st_q == ST_SHIFT);
    assign trail = ext_clk ? ext_rise : (!isck_q && div_q == '0 && st_q == ST_SHIFT);

    assign status = {2'b00, empty_q, full_q, active_q, (st_q == ST_SHIFT), 2'b00};

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        ctrl_d   = ctrl_q;
        buf_d    = buf_q;
        shreg_d  = shreg_q;
        cnt_d    = cnt_q;
        full_d   = full_q;
        empty_d  = empty_q;
        active_d = active_q;
        drop_d   = drop_q;
        sdo_d    = sdo_q;
        isck_d   = isck_q;
        irq_d    = 1'b0;
        div_d    = div_q;
        st_d     = st_q;
        rdata_d  = rdata_q;

        // Software side of the buffer
        if (wr_ctrl) begin
            ctrl_d = wdata;
            if (wdata[CTRL_MODE_LSB +: 2] != ctrl_q[CTRL_MODE_LSB +: 2]) begin
                buf_d   = 8'h00;
                full_d  = 1'b0;
                empty_d = 1'b1;
            end
        end
        if (wr_data) begin
            buf_d   = wdata;
            empty_d = 1'b0;
        end
        if (rd_data) begin
            full_d = 1'b0;
            drop_d = 1'b0;
        end
        case (addr)
            OFF_CTRL:   rdata_d = ctrl_q;
            OFF_DATA:   rdata_d = buf_q;
            OFF_STATUS: rdata_d = status;
            default:    rdata_d = 8'h00;
        endcase
        if (!rd_any) begin
            rdata_d = 8'h00;
        end

        // Internal clock divider
        if (!ext_clk && st_q == ST_SHIFT) begin
            if (div_q == '0) begin
                div_d  = half - DIV_W'(1);
                isck_d = ~isck_q;
            end else begin
                div_d = div_q - DIV_W'(1);
            end
        end else begin
            isck_d = 1'b1;
            div_d  = '0;
        end

        case (st_q)
            ST_IDLE: begin
                if (start && !inhibit && ctrl_q[CTRL_MODE_LSB +: 2] != MODE_RSVD) begin
                    active_d = 1'b1;
                    cnt_d    = 3'h0;
                    st_d     = ST_SHIFT;
                    if (do_tx) begin
                        shreg_d = buf_q;
                        empty_d = 1'b1;
                        irq_d   = (mode == MODE_TX);
                    end
                end
            end
            ST_SHIFT: begin
                if (lead && do_tx) begin
                    sdo_d   = shreg_q[0];
                end
                if (trail) begin
                    shreg_d = in_byte;
                    cnt_d   = cnt_q + 3'h1;
                    if (cnt_q == LAST_BIT) begin
                        if (do_rx) begin
                            if (!drop_q && !full_q) begin
                                buf_d  = in_byte;
                                full_d = 1'b1;
                                irq_d  = 1'b1;
                            end else begin
                                drop_d = 1'b1;
                            end
                        end
                        if (!start) begin
                            st_d = ST_DONE;
                        end else if (!ext_clk) begin
                            st_d = ST_WAIT;
                        end else if (do_tx) begin
                            // Unrefilled buffer shifts out again as a dummy
                            shreg_d = buf_q;
                            empty_d = 1'b1;
                            irq_d   = (mode == MODE_TX);
                        end
                    end
                end
            end
            ST_WAIT: begin
                if (!start) begin
                    st_d = ST_DONE;
                end else if ((!do_tx || !empty_q) && (!do_rx || !full_q)) begin
                    st_d = ST_SHIFT;
                    if (do_tx) begin
                        shreg_d = buf_q;
                        empty_d = 1'b1;
                        irq_d   = (mode == MODE_TX);
                    end
                end
            end
            ST_DONE: begin
                active_d = 1'b0;
                st_d     = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase

        // Inhibit aborts at once; received data is invalid
        if (inhibit && st_q != ST_IDLE) begin
            st_d     = ST_IDLE;
            active_d = 1'b0;
            full_d   = 1'b0;
            drop_d   = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q   <= CTRL_RESET;
            buf_q    <= 8'h00;
            shreg_q  <= 8'h00;
            cnt_q    <= 3'h0;
            full_q   <= 1'b0;
            empty_q  <= 1'b1;
            active_q <= 1'b0;
            drop_q   <= 1'b0;
            sdo_q    <= 1'b1;
            isck_q   <= 1'b1;
            irq_q    <= 1'b0;
            div_q    <= '0;
            st_q     <= ST_IDLE;
            rdata_q  <= 8'h00;
        end else if (ce) begin
            ctrl_q   <= ctrl_d;
            buf_q    <= buf_d;
            shreg_q  <= shreg_d;
            cnt_q    <= cnt_d;
            full_q   <= full_d;
            empty_q  <= empty_d;
            active_q <= active_d;
            drop_q   <= drop_d;
            sdo_q    <= sdo_d;
            isck_q   <= isck_d;
            irq_q    <= irq_d;
            div_q    <= div_d;
            st_q     <= st_d;
            rdata_q  <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rdata      = rdata_q;
    assign sdo        = sdo_q;
    assign sck_out    = isck_q;
    assign sck_oe     = !ext_clk;
    assign serial_irq = irq_q;
endmodule // sio_shifter

// ---- sim/sio_asserts.sv ----
/* Port checker for sio_shifter.
 Assumes the bind at the foot and the package constants. */
`timescale 1ns/1ns
module sio_asserts (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       ce,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       sck_in,
    input wire logic       sck_out,
    input wire logic       sck_oe,
    input wire logic       sdi,
    input wire logic       sdo,
    input wire logic       serial_irq
);
    import sio_pkg::*;
    logic [7:0] ctl_q, ctl_d;
    logic [4:0] rise_q, rise_d;
    logic       sck_q;
    // ----
    // Control mirror and clock rise count
    // ----
    always_comb begin
        ctl_d = ctl_q;
        rise_d = rise_q;
        if (wr && addr == OFF_CTRL) ctl_d = wdata;
        if ((wr || rd) && addr != OFF_STATUS) rise_d = 5'h0;
        else if (sck_oe && sck_out && !sck_q) rise_d = rise_q + 5'h1;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctl_q <= CTRL_RESET;
            rise_q <= 5'h0;
            sck_q <= 1'h1;
        end else begin
            ctl_q <= ctl_d;
            rise_q <= rise_d;
            sck_q <= sck_out;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ----
    // Assertions
    // ----
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside read slot");
    a_unmapped_rd: assert property (rd && addr > OFF_STATUS |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_oe_source: assert property (sck_oe == (ctl_q[2:0] != SCK_EXTERNAL))
        else $error("clock drive does not follow source");
    a_auto_wait: assert property (rise_q <= 5'h10)
        else $error("clock ran on without buffer access");
    a_irq_pulse: assert property (serial_irq |=> !serial_irq)
        else $error("interrupt longer than one cycle");
    a_tx_load_irq: assert property (wr && addr == OFF_CTRL && wdata[7:4] == 4'h8
        && !ctl_q[CTRL_START_BIT] |-> ##[1:3] serial_irq)
        else $error("no empty interrupt after start");
    a_inhibit_halt: assert property (wr && addr == OFF_CTRL && wdata[CTRL_INH_BIT]
        && wdata[2:0] != SCK_EXTERNAL && ctl_q[CTRL_START_BIT] |-> ##4 sck_out [*8])
        else $error("clock kept running after inhibit");
    a_sdo_hold: assert property (sck_oe && sck_out && $past(sck_out)
        && $past(sck_out, 2) && !$past(wr) |-> $stable(sdo))
        else $error("data out changed without falling clock");
    c_irq: cover property (serial_irq);
    c_data_rd: cover property (rd && addr == OFF_DATA);
    c_ext_fall: cover property (!sck_oe && $fell(sck_in));
endmodule // sio_asserts

bind sio_shifter sio_asserts u_sio_asserts (.clk(clk), .rstn(rstn), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sck_in(sck_in),
    .sck_out(sck_out), .sck_oe(sck_oe), .sdi(sdi), .sdo(sdo), .serial_irq(serial_irq));

// ---- sim/sio_peer.sv ----
/* Far-side serial peripheral model.
 Assumes the bench resolves the shared clock pin. */
`timescale 1ns/1ns
module sio_peer (
    input  wire logic       sck,
    input  wire logic       sdo,
    input  wire logic       go,
    input  wire logic [7:0] send,
    output logic            sck_drv,
    output logic            sdi,
    output logic      [7:0] got
);
    int ti;
    initial begin
        sck_drv = 1'h1;
        sdi = 1'h0;
        got = 8'h00;
        ti = 0;
    end
    // ----
    // External clock, idle high between frames
    // ----
    always @(posedge go) begin
        #37;
        repeat (8) begin
            #400 sck_drv = 1'h0;
            #400 sck_drv = 1'h1;
        end
    end
    // ----
    // Data lines
    // ----
    always @(negedge sck) begin
        sdi = send[ti];
        ti = (ti + 1) % 8;
    end
    always @(posedge sck) begin
        got = {sdo, got[7:1]};
        #350 if (ti == 0) sdi = ~sdi;
    end
endmodule // sio_peer

// ---- sim/sio_shifter_tb.sv ----
/* Self-checking bench for sio_shifter.
 Assumes the peer model and checker are compiled alongside. */
`timescale 1ns/1ns
module sio_shifter_tb;
    import sio_pkg::*;
    logic       clk = 1'h0, rstn = 1'h0, ce = 1'h1, wr = 1'h0, rd = 1'h0, go = 1'h0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, send = 8'h00, rdata, got, rv, nx;
    logic       sck_out, sck_oe, sdo, serial_irq, sck_drv, sdi, sck_pin;
    logic [31:0] seed = 32'h0333F741;
    logic [7:0] exp_q[$];
    int         err_total = 0, tests_run = 0, rises = 0, irqs = 0, snap;
    always #50 clk = ~clk;
    assign sck_pin = sck_oe ? sck_out : sck_drv;
    always @(posedge sck_pin) rises++;
    always @(posedge clk) if (serial_irq) irqs++;
    sio_shifter u_sio_shifter (.clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .sck_in(sck_pin), .sck_out(sck_out),
        .sck_oe(sck_oe), .sdi(sdi), .sdo(sdo), .serial_irq(serial_irq));
    sio_peer u_sio_peer (.sck(sck_pin), .sdo(sdo), .go(go), .send(send),
        .sck_drv(sck_drv), .sdi(sdi), .got(got));
    // ----
    // Helpers
    // ----
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic chk(string what, logic [7:0] e, logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wreg(logic [3:0] a, logic [7:0] d);
        @(posedge clk);
        wr <= 1'h1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task automatic rreg(logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'h1;
        addr <= a;
        @(posedge clk);
        rd <= 1'h0;
        #1 d = rdata;
    endtask
    task automatic wait_rises(int n);
        for (int k = 0; k < 3000 && rises < n; k++) @(posedge clk);
        if (rises < n) chk("rises", n[7:0], rises[7:0]);
    endtask
    task automatic poll_idle();
        logic [7:0] s;
        s = 8'hFF;
        for (int k = 0; k < 60 && s[STAT_ACTIVE_BIT] !== 1'h0; k++) rreg(OFF_STATUS, s);
        chk("active", 8'h00, {7'h0, s[STAT_ACTIVE_BIT]});
    endtask
    task automatic end_of_test();
        if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #2000000;
        err_total++;
        end_of_test();
    end
    // ----
    // Scenarios
    // ----
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        rreg(OFF_CTRL, rv);
        chk("ctrl_reset", CTRL_RESET, rv);
        rreg(4'hF, rv);
        chk("unmapped", 8'h00, rv);
        chk("oe_reset", 8'h00, {7'h0, sck_oe});
        wreg(OFF_CTRL, 8'h41);
        rises = 0;
        for (int i = 0; i < 2; i++) begin
            rv = rnd();
            wreg(OFF_DATA, rv);
            if (i == 0) wreg(OFF_CTRL, 8'h81);
            if (i == 0) rreg(OFF_STATUS, snap[7:0]);
            if (i == 0) chk("tx_status", 8'h28, snap[7:0] & 8'h38);
            wait_rises(8 * (i + 1));
            repeat (20) @(posedge clk);
            chk("tx_byte", rv, got);
            chk("tx_stall", 8'(8 * (i + 1)), rises[7:0]);
            chk("sdo_last", {7'h0, rv[7]}, {7'h0, sdo});
        end
        chk("tx_irqs", 8'h02, irqs[7:0]);
        wreg(OFF_CTRL, 8'h01);
        poll_idle();
        wreg(OFF_CTRL, 8'h72);
        u_sio_peer.ti = 0;
        rises = 0;
        irqs = 0;
        send = rnd();
        exp_q.push_back(send);
        wreg(OFF_CTRL, 8'hB2);
        for (int i = 0; i < 2; i++) begin
            wait_rises(8 * (i + 1));
            repeat (20) @(posedge clk);
            chk("rx_stall", 8'(8 * (i + 1)), rises[7:0]);
            if (i == 0) send = rnd();
            if (i == 0) exp_q.push_back(send);
            rreg(OFF_DATA, rv);
            chk("rx_byte", exp_q.pop_front(), rv);
        end
        chk("rx_irqs", 8'h02, irqs[7:0]);
        wreg(OFF_CTRL, 8'h32);
        poll_idle();
        rreg(OFF_DATA, rv);
        u_sio_peer.ti = 0;
        rises = 0;
        wreg(OFF_CTRL, 8'hB2);
        wait_rises(3);
        wreg(OFF_CTRL, 8'h72);
        repeat (3) @(posedge clk);
        snap = rises;
        repeat (30) @(posedge clk);
        chk("inh_clock", snap[7:0], rises[7:0]);
        rreg(OFF_STATUS, rv);
        chk("inh_status", 8'h00, rv & 8'h18);
        wreg(OFF_CTRL, 8'h62);
        u_sio_peer.ti = 0;
        rises = 0;
        nx = rnd();
        send = rnd();
        wreg(OFF_DATA, nx);
        wreg(OFF_CTRL, 8'hA2);
        for (int i = 0; i < 2; i++) begin
            wait_rises(8 * (i + 1));
            repeat (20) @(posedge clk);
            chk("dx_tx", nx, got);
            rreg(OFF_DATA, rv);
            chk("dx_rx", send, rv);
            repeat (40) @(posedge clk);
            chk("dx_hold", 8'(8 * (i + 1)), rises[7:0]);
            nx = rnd();
            send = rnd();
            if (i == 0) wreg(OFF_DATA, nx);
        end
        wreg(OFF_CTRL, 8'h22);
        poll_idle();
        wreg(OFF_CTRL, 8'h77);
        #1;
        chk("oe_ext", 8'h00, {7'h0, sck_oe});
        u_sio_peer.ti = 0;
        rises = 0;
        wreg(OFF_CTRL, 8'hB7);
        for (int i = 0; i < 4; i++) begin
            send = rnd();
            if (i < 2) exp_q.push_back(send);
            go <= 1'h1;
            @(posedge clk);
            go <= 1'h0;
            wait_rises(8 * (i + 1));
            repeat (10) @(posedge clk);
            if (i == 0 || i == 2) rreg(OFF_DATA, rv);
            if (i == 0 || i == 2) chk("ext_rx", exp_q.pop_front(), rv);
        end
        wreg(OFF_CTRL, 8'h47);
        rreg(OFF_DATA, rv);
        chk("mode_clear", 8'h00, rv);
        nx = rnd();
        wreg(OFF_DATA, nx);
        wreg(OFF_CTRL, 8'h87);
        rv = rnd();
        wreg(OFF_DATA, rv);
        rises = 0;
        for (int i = 0; i < 2; i++) begin
            go <= 1'h1;
            @(posedge clk);
            go <= 1'h0;
            wait_rises(8 * (i + 1));
            repeat (10) @(posedge clk);
            chk("ext_tx", (i == 0) ? nx : rv, got);
            if (i == 0) wreg(OFF_CTRL, 8'h07);
        end
        chk("ext_sdo", {7'h0, rv[7]}, {7'h0, sdo});
        poll_idle();
        end_of_test();
    end
endmodule // sio_shifter_tb
